// *** rtl/o2trm_supervisor.sv ***
// O2 trim supervisor: mode sequencing, trim computation and AXI4-Lite registers.
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "o2trm_consts.svh"
// Overview of operation
// - Control differential is setpoint minus measured O2; it drives the air reduction.
// - Air reduction moves all air actuators to one lower load point together.
// - Unmodified ratio curve means air rate equals fuel rate.
// - Manual setpoint definition stores ratio O2, setpoint and relative air reduction.
// - Stored reduction is a percentage of the present air rate.
// - Lambda factor is (ratio lambda minus setpoint lambda) over reduction, times 100.
// - Ideal burner, lambda 0.9 at ten percent reduction, gives lambda factor one.
// - Precontrol uses fuel, ratio O2, setpoint and reduction to hold setpoint at any load.
// - Plus ten percent manipulated variable offsets minus ten percent air density.
// - Pressure-dependent compensation includes the lambda factor for density changes.
// - Ideal-model compensation ignores the lambda factor for density changes.
// - Manual off disables trim and monitor; actuators follow ratio curves.
// - Monitor-only runs monitor, no trim, blocks startup until sensor is warm.
// - Trim-and-monitor runs both and blocks startup until sensor is warm.
// - In monitor or trim mode any fault or trip causes safety shutdown.
// - Auto-fallback mode starts burner early; trim only after warm-up and sensor test.
// - Auto-fallback faults disable trim and monitor, set fallback mode, signal display.
// - Fallback error code is held until operator selects off or an active mode.
module o2trm_supervisor #(
    parameter int DW = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [DW-1:0] o2_measured,
    input wire logic [DW-1:0] load_point,
    input wire logic sensor_warm,
    input wire logic sensor_test_ok,
    input wire logic monitor_trip,
    input wire logic o2_fault,
    input wire logic [7:0] fault_code,
    output logic [DW-1:0] air_load_cmd,
    output logic trim_active,
    output logic monitor_active,
    output logic startup_block,
    output logic safety_shutdown,
    output logic fallback_display,
    output o2trm_pkg::o2trm_mode_t trim_supervision_mode
);
    import o2trm_pkg::*;
    default clocking main_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ==========================================================================
    // Register bus
    logic [7:0] awaddr_q;
    logic aw_held_q;
    logic [31:0] wdata_q;
    logic w_held_q;
    logic wr_fire;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [3:0] wstrb_q;
    o2trm_mode_t mode_q;
    logic dens_pressure_q;
    logic fuel_oil_q;
    logic [DW-1:0] setp_q;
    logic [DW-1:0] ref_q;
    logic [DW-1:0] norm_q;
    logic [DW-1:0] lambda_q;
    logic [DW-1:0] reduct_q;
    logic [7:0] err_code_q;
    logic [DW-1:0] air_q;
    logic capture_req;

    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign wa = aw_held_q ? awaddr_q : s_axi_awaddr;
    assign wd = w_held_q ? wdata_q : s_axi_wdata;
    // Strobes are held with the data, so a late address still uses the strobes sent with it.
    assign ws = w_held_q ? wstrb_q : s_axi_wstrb;
    assign wr_fire = (aw_held_q || s_axi_awvalid) && (w_held_q || s_axi_wvalid) && !s_axi_bvalid;
    assign capture_req = wr_fire && wa == `O2TRM_OFF_CAPTURE && wd[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `O2TRM_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wa > `O2TRM_OFF_CAPTURE || wa[1:0] != 2'b00) ?
                `O2TRM_RESP_SLVERR : `O2TRM_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Configuration writes; byte strobe 0 alone gates every field.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dens_pressure_q <= 1'b0;
            fuel_oil_q <= 1'b0;
            setp_q <= `O2TRM_SETP_RESET;
        end else if (wr_fire && ws[0]) begin
            case (wa)
                `O2TRM_OFF_CFG: begin
                    dens_pressure_q <= wd[`O2TRM_CFG_DENS_BIT];
                    fuel_oil_q <= wd[`O2TRM_CFG_FUEL_BIT];
                end
                `O2TRM_OFF_SETP: setp_q <= wd[DW-1:0];
                default: ;
            endcase
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `O2TRM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `O2TRM_RESP_OKAY;
            case (s_axi_araddr)
                `O2TRM_OFF_MODE: s_axi_rdata <= {21'h00_0000, err_code_q, mode_q};
                `O2TRM_OFF_CFG: s_axi_rdata <= {30'h0000_0000, fuel_oil_q, dens_pressure_q};
                `O2TRM_OFF_SETP: s_axi_rdata <= {{(32-DW){1'b0}}, setp_q};
                `O2TRM_OFF_REF: s_axi_rdata <= {{(32-DW){1'b0}}, ref_q};
                `O2TRM_OFF_NORM: s_axi_rdata <= {{(32-DW){1'b0}}, norm_q};
                `O2TRM_OFF_LAMBDA: s_axi_rdata <= {{(32-DW){1'b0}}, lambda_q};
                `O2TRM_OFF_STATUS: s_axi_rdata <= {26'h000_0000, fallback_display,
                    safety_shutdown, startup_block, monitor_active, trim_active, sensor_warm};
                `O2TRM_OFF_REDUCT: s_axi_rdata <= {{(32-DW){1'b0}}, reduct_q};
                `O2TRM_OFF_LOADOUT: s_axi_rdata <= {{(32-DW){1'b0}}, air_q};
                `O2TRM_OFF_CAPTURE: s_axi_rdata <= 32'h0000_0000;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `O2TRM_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================================
    // Mode sequencing
    logic mode_wr;
    logic active_fault;
    logic fallback_event;
    assign mode_wr = wr_fire && wa == `O2TRM_OFF_MODE;
    assign active_fault = monitor_trip || o2_fault;
    // In auto-fallback mode the failed sensor test also counts as a fault once warm.
    assign fallback_event = mode_q == O2TRM_TRIM_AUTO_FALLBACK &&
        (active_fault || (sensor_warm && !sensor_test_ok));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= o2trm_mode_t'(`O2TRM_MODE_RESET);
            err_code_q <= 8'h00;
        end else if (fallback_event) begin
            // The fault wins over a mode write in the same cycle so it is never lost.
            mode_q <= O2TRM_FALLBACK;
            err_code_q <= fault_code;
        end else if (mode_wr && wd[2:0] <= 3'(O2TRM_TRIM_AUTO_FALLBACK)) begin
            mode_q <= o2trm_mode_t'(wd[2:0]);
            err_code_q <= 8'h00;
        end
    end

    always_comb begin
        trim_active = 1'b0;
        monitor_active = 1'b0;
        startup_block = 1'b0;
        safety_shutdown = 1'b0;
        fallback_display = 1'b0;
        case (mode_q)
            O2TRM_MANUAL_OFF: ;
            O2TRM_MONITOR_ONLY: begin
                monitor_active = 1'b1;
                startup_block = !sensor_warm;
                safety_shutdown = active_fault;
            end
            O2TRM_TRIM_AND_MONITOR: begin
                monitor_active = 1'b1;
                trim_active = 1'b1;
                startup_block = !sensor_warm;
                safety_shutdown = active_fault;
            end
            O2TRM_TRIM_AUTO_FALLBACK: begin
                monitor_active = 1'b1;
                trim_active = sensor_warm && sensor_test_ok;
            end
            O2TRM_FALLBACK: fallback_display = 1'b1;
            default: ;
        endcase
    end
    assign trim_supervision_mode = mode_q;

    // ==========================================================================
    // Setpoint capture and lambda factor
    logic signed [DW+7:0] lam_num;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_q <= '0;
            norm_q <= '0;
        end else if (capture_req) begin
            ref_q <= o2_measured;
            norm_q <= {{(DW-15){1'b0}}, wd[15:1]};
        end
    end

    // Lambda is approximated by the O2 level in percent units.
    // Scale chosen so a ten percent reduction with a ten point change reads 100.
    assign lam_num = (DW+8)'(($signed({1'b0, ref_q}) - $signed({1'b0, setp_q})) * 100);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lambda_q <= `O2TRM_LAMBDA_IDEAL;
        end else if (norm_q != '0) begin
            lambda_q <= DW'(lam_num / $signed({1'b0, norm_q}));
        end
    end

    // ==========================================================================
    // Trim computation
    logic signed [DW:0] diff;
    logic [DW-1:0] reduct_d;
    logic [DW-1:0] dens_term;
    assign diff = $signed({1'b0, setp_q}) - $signed({1'b0, o2_measured});
    // Precontrol reduction plus the corrective part of the differential.
    assign dens_term = dens_pressure_q ? DW'(32'(diff[DW-1:0]) * lambda_q / 100)
        : diff[DW-1:0];
    always_comb begin
        reduct_d = norm_q;
        if (!diff[DW]) begin
            reduct_d = DW'(norm_q + dens_term[DW-1:0]);
        end
        if (reduct_d > `O2TRM_PCT_SCALE) begin
            reduct_d = `O2TRM_PCT_SCALE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reduct_q <= '0;
            air_q <= '0;
        end else if (trim_active) begin
            reduct_q <= reduct_d;
            // Percentage of the present load point, so points scale with load.
            air_q <= DW'(load_point - DW'(32'(load_point) * reduct_d / 100));
        end else begin
            reduct_q <= '0;
            air_q <= load_point;
        end
    end
    assign air_load_cmd = air_q;

    // ==========================================================================
    // Checks
    a_fallback_sets: assert property (
        fallback_event |=> mode_q == O2TRM_FALLBACK && fallback_display)
        else $error("fallback not entered");
    a_fallback_reject: assert property (
        mode_wr && !fallback_event && wd[2:0] == 3'h4 |=> mode_q == $past(mode_q))
        else $error("fallback write accepted");
    a_off_idle: assert property (
        mode_q == O2TRM_MANUAL_OFF |-> !trim_active && !monitor_active)
        else $error("manual off not idle");
    a_off_curve: assert property (
        mode_q == O2TRM_MANUAL_OFF ##1 mode_q == O2TRM_MANUAL_OFF
        |-> air_load_cmd == $past(load_point))
        else $error("ratio curve not followed");
    a_monitor_block: assert property (
        mode_q == O2TRM_MONITOR_ONLY |-> !trim_active && startup_block == !sensor_warm)
        else $error("monitor mode wrong");
    a_trim_block: assert property (
        mode_q == O2TRM_TRIM_AND_MONITOR && !sensor_warm |-> startup_block)
        else $error("startup not blocked");
    a_shutdown_cause: assert property (
        (mode_q == O2TRM_MONITOR_ONLY || mode_q == O2TRM_TRIM_AND_MONITOR) && monitor_trip
        |-> safety_shutdown)
        else $error("no safety shutdown");
    a_auto_start: assert property (
        mode_q == O2TRM_TRIM_AUTO_FALLBACK |-> !startup_block
        && trim_active == (sensor_warm && sensor_test_ok))
        else $error("auto mode trim wrong");
    a_err_hold: assert property (
        mode_q == O2TRM_FALLBACK && !mode_wr |=> err_code_q == $past(err_code_q))
        else $error("error code lost");
    a_capture: assert property (
        capture_req |=> ref_q == $past(o2_measured))
        else $error("capture missed");
    a_off_quiet: assert property (
        mode_q == O2TRM_MANUAL_OFF |-> !startup_block && !safety_shutdown && !fallback_display)
        else $error("manual off not quiet");
    a_fault_shutdown: assert property (
        (mode_q == O2TRM_MONITOR_ONLY || mode_q == O2TRM_TRIM_AND_MONITOR) && o2_fault
        |-> safety_shutdown)
        else $error("fault without shutdown");
    a_trim_both: assert property (
        mode_q == O2TRM_TRIM_AND_MONITOR |-> trim_active && monitor_active)
        else $error("trim mode not running");
    a_auto_no_stop: assert property (
        mode_q == O2TRM_TRIM_AUTO_FALLBACK |-> !safety_shutdown)
        else $error("auto mode shut down");
    a_fallback_idle: assert property (
        mode_q == O2TRM_FALLBACK |-> !trim_active && !monitor_active && !startup_block)
        else $error("fallback still active");
    a_fallback_curve: assert property (
        mode_q == O2TRM_FALLBACK ##1 mode_q == O2TRM_FALLBACK
        |-> air_load_cmd == $past(load_point))
        else $error("fallback off curve");
    a_err_capture: assert property (
        fallback_event |=> err_code_q == $past(fault_code))
        else $error("error code not taken");
    a_err_clear: assert property (
        mode_wr && !fallback_event && wd[2:0] < 3'h4 |=> err_code_q == 8'h00)
        else $error("error code not cleared");
    a_load_follow: assert property (
        !trim_active |=> air_load_cmd == $past(load_point))
        else $error("load not on ratio curve");
    a_trim_lower: assert property (
        trim_active |=> air_load_cmd <= $past(load_point))
        else $error("trim raised the air");
    a_idle_reduct: assert property (
        !trim_active |=> reduct_q == '0)
        else $error("reduction left applied");
    a_ideal_model: assert property (
        !dens_pressure_q |-> dens_term == diff[DW-1:0])
        else $error("ideal model uses lambda");
    c_fallback: cover property (fallback_event);
    c_shutdown: cover property (safety_shutdown);
    c_trim: cover property (trim_active ##1 trim_active);
    c_capture: cover property (capture_req);
    c_fallback_exit: cover property (mode_q == O2TRM_FALLBACK ##1 mode_q == O2TRM_MANUAL_OFF);
endmodule : o2trm_supervisor

// *** rtl/o2trm_consts.svh ***
// Register offsets, field positions, reset values and arithmetic constants of the O2 trim supervisor.
`ifndef O2TRM_CONSTS_SVH
`define O2TRM_CONSTS_SVH
// ==========================================================================
// Register byte offsets
`define O2TRM_OFF_MODE 8'h00
`define O2TRM_OFF_CFG 8'h04
`define O2TRM_OFF_SETP 8'h08
`define O2TRM_OFF_REF 8'h0C
`define O2TRM_OFF_NORM 8'h10
`define O2TRM_OFF_LAMBDA 8'h14
`define O2TRM_OFF_STATUS 8'h18
`define O2TRM_OFF_REDUCT 8'h1C
`define O2TRM_OFF_LOADOUT 8'h20
`define O2TRM_OFF_CAPTURE 8'h24
// ==========================================================================
// Field positions and reset values
`define O2TRM_CFG_DENS_BIT 0
`define O2TRM_CFG_FUEL_BIT 1
`define O2TRM_MODE_RESET 3'h0
`define O2TRM_SETP_RESET 16'h0000
// ==========================================================================
// Arithmetic scale: lambda factor 1.0 is 100 (percent units, scaled by one hundred).
`define O2TRM_PCT_SCALE 16'h0064
`define O2TRM_LAMBDA_IDEAL 16'h0064
`define O2TRM_RESP_OKAY 2'h0
`define O2TRM_RESP_SLVERR 2'h2
`endif

// *** rtl/o2trm_pkg.sv ***
// Types shared by the O2 trim supervisor.
package o2trm_pkg;
    // ==========================================================================
    // Mode encoding of the three-bit trim_supervision_mode field.
    typedef enum logic [2:0] {
        O2TRM_MANUAL_OFF = 3'h0,
        O2TRM_MONITOR_ONLY = 3'h1,
        O2TRM_TRIM_AND_MONITOR = 3'h2,
        O2TRM_TRIM_AUTO_FALLBACK = 3'h3,
        O2TRM_FALLBACK = 3'h4
    } o2trm_mode_t;
    typedef enum logic [1:0] {
        O2TRM_W_IDLE,
        O2TRM_W_RESP
    } o2trm_wr_t;
endpackage : o2trm_pkg

// *** tb/o2trm_o2_model.sv ***
// Behavioural model of the O2 measurement module and sensor that feed the supervisor.
`timescale 1ns/100ps
module o2trm_o2_model (
    input wire logic aclk,
    output logic [15:0] o2_measured,
    output logic sensor_warm,
    output logic sensor_test_ok,
    output logic monitor_trip,
    output logic o2_fault,
    output logic [7:0] fault_code
);
    // ==========================================================================
    // Power-on state
    // The sensor starts cold, so monitor-only and trim-and-monitor modes see a blocked start.
    initial begin
        o2_measured = 16'h0000;
        sensor_warm = 1'h0;
        sensor_test_ok = 1'h0;
        monitor_trip = 1'h0;
        o2_fault = 1'h0;
        fault_code = 8'h00;
    end
    // ==========================================================================
    // Commanded state
    // All levels change together after an edge, so no half-updated set is ever sampled.
    task automatic drive(input logic w, input logic t, input logic tr, input logic f,
                         input logic [7:0] c, input logic [15:0] o2);
        @(posedge aclk);
        sensor_warm <= w;
        sensor_test_ok <= t;
        monitor_trip <= tr;
        o2_fault <= f;
        fault_code <= c;
        o2_measured <= o2;
    endtask : drive
endmodule : o2trm_o2_model

// *** tb/tb_o2trm_supervisor.sv ***
// Self-checking bench of the O2 trim supervisor.
`timescale 1ns/100ps
`include "o2trm_consts.svh"
module tb_o2trm_supervisor;
    import o2trm_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rd;
    logic [15:0] o2_measured, air_load_cmd;
    logic [15:0] load_point = 16'h0050;
    logic sensor_warm, sensor_test_ok, monitor_trip, o2_fault;
    logic [7:0] fault_code;
    logic trim_active, monitor_active, startup_block, safety_shutdown, fallback_display;
    o2trm_mode_t mode_o;
    int errors = 0;
    int num_checks = 0;

    always #2 aclk = ~aclk;

    o2trm_o2_model sensor (.aclk(aclk), .o2_measured(o2_measured), .sensor_warm(sensor_warm),
        .sensor_test_ok(sensor_test_ok), .monitor_trip(monitor_trip), .o2_fault(o2_fault),
        .fault_code(fault_code));

    o2trm_supervisor dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .o2_measured(o2_measured), .load_point(load_point), .sensor_warm(sensor_warm),
        .sensor_test_ok(sensor_test_ok), .monitor_trip(monitor_trip), .o2_fault(o2_fault),
        .fault_code(fault_code), .air_load_cmd(air_load_cmd), .trim_active(trim_active),
        .monitor_active(monitor_active), .startup_block(startup_block),
        .safety_shutdown(safety_shutdown), .fallback_display(fallback_display),
        .trim_supervision_mode(mode_o));

    // ==========================================================================
    // Reporting
    task automatic finish_test();
        $display("Checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    function automatic logic [4:0] flags();
        return {trim_active, monitor_active, startup_block, safety_shutdown, fallback_display};
    endfunction : flags

    // Outputs are combinational from registered state, so two edges always settle them.
    task automatic settle();
        repeat (2) @(posedge aclk);
        @(negedge aclk);
    endtask : settle

    // ==========================================================================
    // Bus master: ready is sampled mid-cycle, where it is settled, and acted on at the edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 64; n++) begin
            @(negedge aclk);
            ta = awvalid && (awready === 1'h1);
            tw = wvalid && (wready === 1'h1);
            if (bvalid === 1'h1) begin
                rsp = bresp;
                @(posedge aclk);
                bready <= 1'h0;
                return;
            end
            @(posedge aclk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
        end
        errors++;
        $display("FAIL %0t write timeout", $time);
        finish_test();
    endtask : wr

    task automatic rd_reg(input logic [7:0] a);
        logic ta;
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 64; n++) begin
            @(negedge aclk);
            ta = arvalid && (arready === 1'h1);
            if (rvalid === 1'h1) begin
                rd = rdata;
                rsp = rresp;
                @(posedge aclk);
                rready <= 1'h0;
                return;
            end
            @(posedge aclk);
            if (ta) arvalid <= 1'h0;
        end
        errors++;
        $display("FAIL %0t read timeout", $time);
        finish_test();
    endtask : rd_reg

    // ==========================================================================
    // Scenarios
    task automatic t_reset();
        settle();
        chk(flags(), 5'h00, "off flags");
        chk(air_load_cmd, load_point, "off load");
        rd_reg(`O2TRM_OFF_MODE);
        chk(rd, 32'h0000_0000, "mode reset");
        rd_reg(`O2TRM_OFF_LAMBDA);
        chk(rd, 32'h0000_0064, "lambda reset");
        rd_reg(8'h3c);
        chk(rsp, `O2TRM_RESP_SLVERR, "unmapped read");
        chk(rd, 32'h0000_0000, "unmapped data");
        wr(8'h3c, 32'h0000_0001);
        chk(rsp, `O2TRM_RESP_SLVERR, "unmapped write");
    endtask : t_reset

    // Every writable mode is set, then each higher code, fallback included, must leave the last one in place.
    task automatic t_modes();
        int m;
        for (m = 0; m < 8; m++) begin
            wr(`O2TRM_OFF_MODE, m);
            rd_reg(`O2TRM_OFF_MODE);
            chk(rd[2:0], (m < 4) ? m : 3, "mode readback");
            chk(mode_o, (m < 4) ? m : 3, "mode port");
        end
        wr(`O2TRM_OFF_CFG, 32'h0000_0001);
        rd_reg(`O2TRM_OFF_CFG);
        chk(rd[1:0], 2'h1, "cfg gas pressure");
    endtask : t_modes

    task automatic t_monitor();
        sensor.drive(1'h0, 1'h0, 1'h0, 1'h0, 8'h00, 16'h001e);
        wr(`O2TRM_OFF_MODE, 32'h0000_0001);
        settle();
        chk(flags(), 5'h0c, "monitor cold");
        sensor.drive(1'h1, 1'h1, 1'h0, 1'h0, 8'h00, 16'h001e);
        settle();
        chk(flags(), 5'h08, "monitor warm");
        sensor.drive(1'h1, 1'h1, 1'h0, 1'h1, 8'h11, 16'h001e);
        settle();
        chk(safety_shutdown, 1'h1, "monitor fault");
    endtask : t_monitor

    task automatic t_trim();
        sensor.drive(1'h0, 1'h0, 1'h0, 1'h0, 8'h00, 16'h001e);
        wr(`O2TRM_OFF_MODE, 32'h0000_0002);
        settle();
        chk({monitor_active, startup_block}, 2'h3, "trim cold");
        sensor.drive(1'h1, 1'h1, 1'h0, 1'h0, 8'h00, 16'h001e);
        settle();
        chk(flags(), 5'h18, "trim warm");
        sensor.drive(1'h1, 1'h1, 1'h1, 1'h0, 8'h00, 16'h001e);
        settle();
        chk(safety_shutdown, 1'h1, "trim trip");
        sensor.drive(1'h1, 1'h1, 1'h0, 1'h0, 8'h00, 16'h001e);
    endtask : t_trim

    // Ratio O2 of 30 with a 10 percent reduction; setpoints step the factor down from 200 to 50.
    task automatic t_lambda();
        int s;
        wr(`O2TRM_OFF_CAPTURE, 32'h0000_0015);
        rd_reg(`O2TRM_OFF_REF);
        chk(rd, 32'h0000_001e, "ratio o2 stored");
        rd_reg(`O2TRM_OFF_NORM);
        chk(rd, 32'h0000_000a, "reduction stored");
        for (s = 10; s <= 25; s += 5) begin
            wr(`O2TRM_OFF_SETP, s);
            rd_reg(`O2TRM_OFF_LAMBDA);
            chk(rd, (30 - s) * `O2TRM_PCT_SCALE / 10, "lambda factor");
        end
    endtask : t_lambda

    task automatic t_fallback();
        sensor.drive(1'h0, 1'h0, 1'h0, 1'h0, 8'h00, 16'h001e);
        wr(`O2TRM_OFF_MODE, 32'h0000_0003);
        settle();
        chk({trim_active, startup_block}, 2'h0, "early start");
        sensor.drive(1'h1, 1'h1, 1'h0, 1'h0, 8'h00, 16'h001e);
        settle();
        chk(trim_active, 1'h1, "trim after test");
        chk(air_load_cmd, 16'h0050 * (100 - 10) / 100, "reduced load");
        @(posedge aclk);
        load_point <= 16'h00c8;
        settle();
        chk(air_load_cmd, 16'h00c8 * (100 - 10) / 100, "reduced larger load");
        rd_reg(`O2TRM_OFF_REDUCT);
        chk(rd, 32'h0000_000a, "precontrol reduction");
        sensor.drive(1'h1, 1'h1, 1'h0, 1'h1, 8'h5a, 16'h001e);
        settle();
        chk(flags(), 5'h01, "fallback flags");
        chk(mode_o, O2TRM_FALLBACK, "fallback mode");
        chk(air_load_cmd, load_point, "fallback load");
        sensor.drive(1'h1, 1'h1, 1'h0, 1'h0, 8'h00, 16'h001e);
        settle();
        rd_reg(`O2TRM_OFF_MODE);
        chk(rd[10:0], {8'h5a, 3'h4}, "code held");
        wr(`O2TRM_OFF_MODE, 32'h0000_0000);
        rd_reg(`O2TRM_OFF_MODE);
        chk(rd[10:0], 11'h000, "code cleared");
    endtask : t_fallback

    // ==========================================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_modes();
        t_monitor();
        t_trim();
        t_lambda();
        t_fallback();
        finish_test();
    end
endmodule : tb_o2trm_supervisor
